// ### hdl/lcf_pkg.sv
// Register map, field positions and reset values of the color and fault register bank
package lcf_pkg;
    localparam int NUM_MODULES = 12;
    localparam int NUM_COLORS = 3;
    localparam int NUM_OPEN_CH = 16;
    localparam int REG_W = 8;
    localparam int LEVEL_W = 12;
    localparam int DIM_W = 6;
    localparam int DELAY_W = 2;
    localparam int IDX_W = 4;

    localparam logic [7:0] RED_BASE = 8'h14;
    localparam logic [7:0] RED_LAST = 8'h1E;
    localparam logic [7:0] RED_SPARE_ADDR = 8'h37;
    localparam logic [7:0] GREEN_BASE = 8'h1F;
    localparam logic [7:0] BLUE_BASE = 8'h2B;
    localparam logic [7:0] SOFT_RESET_ADDR = 8'h38;
    localparam logic [7:0] FLAGS_ADDR = 8'h65;
    localparam logic [7:0] DIM_ADDR = 8'h66;
    localparam logic [7:0] DELAY_ADDR = 8'h67;
    localparam logic [7:0] MASK_ADDR = 8'h68;
    localparam logic [7:0] OPEN_MASK_LO_ADDR = 8'h6A;
    localparam logic [7:0] OPEN_MASK_HI_ADDR = 8'h6B;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] SOFT_RESET_KEY = 8'hFF;
    localparam logic [7:0] MIX_ZERO = 8'h00;
    localparam logic [7:0] MIX_HALF = 8'h80;
    localparam logic [7:0] MIX_FULL = 8'hFF;
    localparam logic [8:0] MIX_UNITY = 9'h100;

    // Flag register bit positions
    localparam int FLAG_POR_BIT = 4;
    localparam int FLAG_UV_BIT = 3;
    localparam int FLAG_OT_BIT = 2;
    localparam int FLAG_SHORT_BIT = 1;
    localparam int FLAG_OPEN_BIT = 0;

    // Mask and clear register bit positions
    localparam int MASK_POR_BIT = 6;
    localparam int MASK_UV_BIT = 5;
    localparam int MASK_OT_BIT = 4;
    localparam int MASK_SHORT_BIT = 3;
    localparam int MASK_OPEN_BIT = 2;
    localparam int FAULT_CLEAR_BIT_BIT = 1;
    localparam int POWER_ON_CLEAR_BIT_BIT = 0;
endpackage

// ### hdl/lcf_regs.sv
// Color-mix, soft reset, global dimming and fault flag/mask register bank
//
// Functional notes
// - Color-mix value scales its channel linearly: 00h none, 80h half, FFh full.
// - Twelve red mix registers at 14h to 1Eh and 37h, read/write, reset to zero.
// - Twelve green mix registers at 1Fh to 2Ah, read/write, reset to zero.
// - Blue mix registers within 2Bh to 36h, read/write, reset to zero.
// - Writing FFh to write-only 38h returns every register to default.
// - Flag register at 65h holds a power-on flag, one when reported.
// - Flag register has separate early undervoltage and early overtemperature bits.
// - Aggregate open and short bits read one when any channel reports fault.
// - Register 66h holds 6-bit global current in low bits, reset zero.
// - Register 67h holds a two-bit fault wait field, reset zero.
// - Register 68h holds mask enables for five reports; one turns mask on.
// - Writing one to power-on clear bit clears power-on flag; zero does nothing.
// - Registers 6Ah and 6Bh hold per-channel open masks for channels 0 to 15.
`timescale 1ns/100ps
module lcf_regs (
    input wire logic CORE_CLK, // Core clock, 100 MHz
    input wire logic RESET, // Synchronous reset, active high
    input wire logic [7:0] REG_ADDR, // Register address from serial front end
    input wire logic [7:0] REG_WDATA, // Write data
    input wire logic REG_WR, // Write strobe, one cycle
    input wire logic REG_RD, // Read strobe, one cycle
    output logic [7:0] REG_RDATA, // Read data, valid with REG_RVALID
    output logic REG_RVALID, // Read data valid pulse
    input wire logic POR_EVENT, // Power-on event report
    input wire logic EARLY_UV_EVENT, // Early undervoltage warning
    input wire logic EARLY_OT_EVENT, // Early overtemperature warning
    input wire logic [15:0] OPEN_DET, // Per-channel open detection, channels 0..15
    input wire logic [15:0] SHORT_DET, // Per-channel short detection, channels 0..15
    input wire logic [11:0] LEVEL_IN, // Brightness level before color mixing
    output logic [95:0] RED_MIX, // Red mix values, module m at [8m+:8]
    output logic [95:0] GREEN_MIX, // Green mix values
    output logic [95:0] BLUE_MIX, // Blue mix values
    output logic [431:0] MIX_LEVEL, // Mixed level, module m color c at [(3m+c)*12+:12]
    output logic [5:0] GLOBAL_DIM, // Global current setting
    output logic [1:0] FAULT_DELAY, // Fault wait selection
    output logic SOFT_RESET_PULSE, // One-cycle reset to the rest of the device
    input wire logic FAULT_IN, // Fault pin level as seen on the wire
    output logic FAULT_OUT, // Fault pin drive value, always low
    output logic FAULT_OE_N // Fault pin enable, low while pulling the pin low
);
    localparam int NM = lcf_pkg::NUM_MODULES;
    localparam int LW = lcf_pkg::LEVEL_W;

    logic [7:0] red_mix [NM];
    logic [7:0] green_mix [NM];
    logic [7:0] blue_mix [NM];
    logic [5:0] global_dim;
    logic [1:0] fault_delay;
    logic [6:2] mask_bits;
    logic [15:0] open_mask;
    logic flag_por;
    logic flag_uv;
    logic flag_ot;
    logic flag_short;
    logic flag_open;
    logic soft_rst;
    logic fault_seen;

    // Membership and index of a register inside a run of NUM_MODULES consecutive addresses
    function automatic logic in_run(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] off;
        off = addr - base;
        return (addr >= base) && (off < 8'(NM));
    endfunction

    function automatic logic [3:0] run_idx(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] off;
        off = addr - base;
        return off[3:0];
    endfunction

    // Linear gain: FFh is promoted to unity so that full scale passes unchanged
    function automatic logic [11:0] mix_scale(input logic [11:0] lvl, input logic [7:0] mix);
        logic [8:0] gain;
        logic [20:0] prod;
        gain = (mix == lcf_pkg::MIX_FULL) ? lcf_pkg::MIX_UNITY : {1'b0, mix};
        prod = 21'(lvl) * 21'(gain);
        return prod[19:8];
    endfunction

    // Address decode
    wire red_lo_hit = (REG_ADDR >= lcf_pkg::RED_BASE) && (REG_ADDR <= lcf_pkg::RED_LAST);
    wire red_hit = red_lo_hit || (REG_ADDR == lcf_pkg::RED_SPARE_ADDR);
    wire [3:0] red_idx = red_lo_hit ? run_idx(REG_ADDR, lcf_pkg::RED_BASE) : 4'(NM - 1);
    wire green_hit = in_run(REG_ADDR, lcf_pkg::GREEN_BASE);
    wire [3:0] green_idx = run_idx(REG_ADDR, lcf_pkg::GREEN_BASE);
    wire blue_hit = in_run(REG_ADDR, lcf_pkg::BLUE_BASE);
    wire [3:0] blue_idx = run_idx(REG_ADDR, lcf_pkg::BLUE_BASE);
    wire wr_dim = REG_WR && (REG_ADDR == lcf_pkg::DIM_ADDR);
    wire wr_delay = REG_WR && (REG_ADDR == lcf_pkg::DELAY_ADDR);
    wire wr_mask = REG_WR && (REG_ADDR == lcf_pkg::MASK_ADDR);
    wire wr_om_lo = REG_WR && (REG_ADDR == lcf_pkg::OPEN_MASK_LO_ADDR);
    wire wr_om_hi = REG_WR && (REG_ADDR == lcf_pkg::OPEN_MASK_HI_ADDR);
    wire soft_req = REG_WR && (REG_ADDR == lcf_pkg::SOFT_RESET_ADDR)
                    && (REG_WDATA == lcf_pkg::SOFT_RESET_KEY);
    wire any_rst = RESET || soft_rst;

    wire power_on_clear_bit = wr_mask && REG_WDATA[lcf_pkg::POWER_ON_CLEAR_BIT_BIT];
    wire fault_clear_bit = wr_mask && REG_WDATA[lcf_pkg::FAULT_CLEAR_BIT_BIT];

    // masked reports never reach their flags
    wire set_por = POR_EVENT && !mask_bits[lcf_pkg::MASK_POR_BIT];
    wire set_uv = EARLY_UV_EVENT && !mask_bits[lcf_pkg::MASK_UV_BIT];
    wire set_ot = EARLY_OT_EVENT && !mask_bits[lcf_pkg::MASK_OT_BIT];
    // aggregate over channels, with per-channel open masks
    wire set_open = (|(OPEN_DET & ~open_mask)) && !mask_bits[lcf_pkg::MASK_OPEN_BIT];
    wire set_short = (|SHORT_DET) && !mask_bits[lcf_pkg::MASK_SHORT_BIT];

    // latch until cleared, a new report wins over a clear
    wire next_flag_por = set_por || (flag_por && !power_on_clear_bit);
    wire next_flag_uv = set_uv || (flag_uv && !fault_clear_bit);
    wire next_flag_ot = set_ot || (flag_ot && !fault_clear_bit);
    wire next_flag_open = set_open || (flag_open && !fault_clear_bit);
    wire next_flag_short = set_short || (flag_short && !fault_clear_bit);

    wire [7:0] flags_image = {3'b000, flag_por, flag_uv, flag_ot, flag_short, flag_open};
    // clear bits always read as zero
    wire [7:0] mask_image = {1'b0, mask_bits, 2'b00};

    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = lcf_pkg::REG_RESET;
        if (red_hit) begin
            next_rdata = red_mix[red_idx];
        end else if (green_hit) begin
            next_rdata = green_mix[green_idx];
        end else if (blue_hit) begin
            next_rdata = blue_mix[blue_idx];
        end else begin
            case (REG_ADDR)
                lcf_pkg::FLAGS_ADDR: next_rdata = flags_image;
                lcf_pkg::DIM_ADDR: next_rdata = {2'b00, global_dim};
                lcf_pkg::DELAY_ADDR: next_rdata = {6'b000000, fault_delay};
                lcf_pkg::MASK_ADDR: next_rdata = mask_image;
                lcf_pkg::OPEN_MASK_LO_ADDR: next_rdata = open_mask[7:0];
                lcf_pkg::OPEN_MASK_HI_ADDR: next_rdata = open_mask[15:8];
                default: next_rdata = lcf_pkg::REG_RESET;
            endcase
        end
    end

    // Soft reset takes effect one cycle after the write, for the whole bank
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= soft_req;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (any_rst) begin
            for (int m = 0; m < NM; m++) begin
                red_mix[m] <= lcf_pkg::REG_RESET;
                green_mix[m] <= lcf_pkg::REG_RESET;
                blue_mix[m] <= lcf_pkg::REG_RESET;
            end
        end else if (REG_WR) begin
            if (red_hit) begin
                red_mix[red_idx] <= REG_WDATA;
            end
            if (green_hit) begin
                green_mix[green_idx] <= REG_WDATA;
            end
            if (blue_hit) begin
                blue_mix[blue_idx] <= REG_WDATA;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (any_rst) begin
            global_dim <= '0;
            fault_delay <= '0;
            mask_bits <= '0;
            open_mask <= '0;
        end else begin
            if (wr_dim) global_dim <= REG_WDATA[5:0];
            if (wr_delay) fault_delay <= REG_WDATA[1:0];
            if (wr_mask) mask_bits <= REG_WDATA[6:2];
            if (wr_om_lo) open_mask[7:0] <= REG_WDATA;
            if (wr_om_hi) open_mask[15:8] <= REG_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (any_rst) begin
            flag_por <= 1'b0;
            flag_uv <= 1'b0;
            flag_ot <= 1'b0;
            flag_open <= 1'b0;
            flag_short <= 1'b0;
        end else begin
            flag_por <= next_flag_por;
            flag_uv <= next_flag_uv;
            flag_ot <= next_flag_ot;
            flag_open <= next_flag_open;
            flag_short <= next_flag_short;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            REG_RDATA <= lcf_pkg::REG_RESET;
            REG_RVALID <= 1'b0;
            SOFT_RESET_PULSE <= 1'b0;
            FAULT_OE_N <= 1'b1;
            FAULT_OUT <= 1'b0;
            fault_seen <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) REG_RDATA <= next_rdata;
            SOFT_RESET_PULSE <= soft_req;
            // only unmasked, latched flags pull the pin, power-on flag included
            FAULT_OE_N <= !(|flags_image);
            // Open-drain pin: the drive value never leaves low
            FAULT_OUT <= 1'b0;
            fault_seen <= FAULT_IN;
        end
    end

    assign GLOBAL_DIM = global_dim;
    assign FAULT_DELAY = fault_delay;

    // mixed levels, registered per module and color
    logic [LW-1:0] level_q [NM*3];
    // One process for the whole array, so each element has a single driver
    always_ff @(posedge CORE_CLK) begin
        for (int m = 0; m < NM; m++) begin
            if (RESET) begin
                level_q[3*m] <= '0;
                level_q[3*m+1] <= '0;
                level_q[3*m+2] <= '0;
            end else begin
                level_q[3*m] <= mix_scale(LEVEL_IN, red_mix[m]);
                level_q[3*m+1] <= mix_scale(LEVEL_IN, green_mix[m]);
                level_q[3*m+2] <= mix_scale(LEVEL_IN, blue_mix[m]);
            end
        end
    end
    for (genvar m = 0; m < NM; m++) begin : g_mod
        assign RED_MIX[8*m +: 8] = red_mix[m];
        assign GREEN_MIX[8*m +: 8] = green_mix[m];
        assign BLUE_MIX[8*m +: 8] = blue_mix[m];
        assign MIX_LEVEL[(3*m)*LW +: LW] = level_q[3*m];
        assign MIX_LEVEL[(3*m+1)*LW +: LW] = level_q[3*m+1];
        assign MIX_LEVEL[(3*m+2)*LW +: LW] = level_q[3*m+2];
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    sequence s_key_write;
        REG_WR && REG_ADDR == lcf_pkg::SOFT_RESET_ADDR && REG_WDATA == lcf_pkg::SOFT_RESET_KEY;
    endsequence

    sequence s_clear_write;
        wr_mask && (REG_WDATA[1:0] != 2'b00);
    endsequence

    sequence s_mask_read;
        REG_RD && REG_ADDR == lcf_pkg::MASK_ADDR;
    endsequence

    a_soft_reset_bank: assert property (s_key_write |-> ##2 (global_dim == '0
        && mask_bits == '0 && red_mix[0] == lcf_pkg::REG_RESET && !flag_por))
        else $error("soft reset did not restore defaults");

    a_por_flag_set: assert property ((POR_EVENT && !mask_bits[lcf_pkg::MASK_POR_BIT]
        && !soft_rst) |=> flag_por)
        else $error("power-on report not latched");

    a_por_clear_works: assert property ((power_on_clear_bit && !POR_EVENT && !soft_rst)
        |=> !flag_por)
        else $error("power-on clear ignored");

    a_clear_set_wins: assert property ((fault_clear_bit && set_uv && !soft_rst)
        |=> flag_uv)
        else $error("clear lost a same-cycle report");

    a_flag_stays_latched: assert property ((flag_ot && !fault_clear_bit && !soft_rst)
        |=> flag_ot)
        else $error("flag dropped without a clear");

    a_open_mask_silent: assert property ((!flag_open && (&open_mask) && !soft_rst)
        |=> !flag_open)
        else $error("masked open fault set the flag");

    a_clear_reads_zero: assert property ((s_clear_write ##2 s_mask_read)
        |=> REG_RVALID && REG_RDATA[1:0] == 2'b00)
        else $error("clear bits read back set");

    a_dim_width: assert property ((wr_dim && !soft_rst) |=>
        global_dim == $past(REG_WDATA[5:0]))
        else $error("global dim field wrong");

    a_dim_reserved: assert property ((REG_RD && REG_ADDR == lcf_pkg::DIM_ADDR)
        |=> REG_RDATA[7:6] == 2'b00)
        else $error("global dim reserved bits set");

    a_mix_full_scale: assert property ((red_mix[0] == lcf_pkg::MIX_FULL)
        |=> MIX_LEVEL[LW-1:0] == $past(LEVEL_IN))
        else $error("full mix does not pass level");

    a_mix_zero_scale: assert property ((green_mix[0] == lcf_pkg::MIX_ZERO)
        |=> MIX_LEVEL[2*LW-1:LW] == '0)
        else $error("zero mix does not block level");

    a_fault_pin_drive: assert property ((|flags_image) |=> !FAULT_OE_N)
        else $error("fault pin not pulled on a flag");

    a_uv_masked_quiet: assert property ((EARLY_UV_EVENT && mask_bits[lcf_pkg::MASK_UV_BIT]
        && !flag_uv && !soft_rst) |=> !flag_uv)
        else $error("masked early undervoltage set the flag");

    a_short_aggregate: assert property (((|SHORT_DET) && !mask_bits[lcf_pkg::MASK_SHORT_BIT]
        && !soft_rst) |=> flag_short)
        else $error("short report not aggregated");

    a_open_aggregate: assert property (((|(OPEN_DET & ~open_mask))
        && !mask_bits[lcf_pkg::MASK_OPEN_BIT] && !soft_rst) |=> flag_open)
        else $error("open report not aggregated");

    a_delay_write: assert property ((wr_delay && !soft_rst) |=>
        fault_delay == $past(REG_WDATA[1:0]))
        else $error("fault delay field wrong");

    a_open_mask_write: assert property ((wr_om_lo && !soft_rst) |=>
        open_mask[7:0] == $past(REG_WDATA))
        else $error("open mask low byte wrong");

    a_soft_pulse_out: assert property (s_key_write |=> SOFT_RESET_PULSE)
        else $error("soft reset pulse missing");

    a_read_valid_echo: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered");
endmodule

// ### tb/lcf_host.sv
// Host-side model of the register access path and the fault pin pull-up
`timescale 1ns/100ps
module lcf_host (
    input wire logic clk, // Core clock
    output logic [7:0] addr, // Register address
    output logic [7:0] wdata, // Write data
    output logic wr, // Write strobe
    output logic rd, // Read strobe
    input wire logic [7:0] rdata, // Read data from the bank
    input wire logic rvalid, // Read data valid
    input wire logic fault_drv, // Device drive value on the fault pin
    input wire logic fault_oe_n, // Device enable, low while pulling
    output logic fault_pin // Resolved fault line level
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // Open-drain line: pull-up wins unless the device enables its driver
    assign fault_pin = fault_oe_n ? 1'b1 : fault_drv;

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        // Released lines must not keep looking valid
        addr = ~a;
        wdata = ~d;
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
        d = rdata;
        v = rvalid;
    endtask
endmodule

// ### tb/tb_lcf_regs.sv
// Self-checking bench for the color-mix and fault register bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; \
    if ((g) !== (e)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_lcf_regs;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, rvalid, srst, fout, foe_n, fin;
    logic por = 1'b0;
    logic uv = 1'b0;
    logic ot = 1'b0;
    logic [15:0] open_det = 16'h0000;
    logic [15:0] short_det = 16'h0000;
    logic [11:0] level = 12'h000;
    logic [95:0] red, green, blue;
    logic [431:0] mixl;
    logic [5:0] gdim;
    logic [1:0] fdel;
    int errors = 0;
    int check_count = 0;
    logic [7:0] regs [8] = '{8'h65, 8'h66, 8'h67, 8'h68, 8'h6A, 8'h6B, 8'h38, 8'h69};
    logic [7:0] scale [3] = '{8'h00, 8'h80, 8'hFF};

    always #5 clk = ~clk;

    lcf_regs dut (.CORE_CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .POR_EVENT(por), .EARLY_UV_EVENT(uv), .EARLY_OT_EVENT(ot), .OPEN_DET(open_det),
        .SHORT_DET(short_det), .LEVEL_IN(level), .RED_MIX(red), .GREEN_MIX(green),
        .BLUE_MIX(blue), .MIX_LEVEL(mixl), .GLOBAL_DIM(gdim), .FAULT_DELAY(fdel),
        .SOFT_RESET_PULSE(srst), .FAULT_IN(fin), .FAULT_OUT(fout), .FAULT_OE_N(foe_n));

    lcf_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rvalid(rvalid), .fault_drv(fout), .fault_oe_n(foe_n), .fault_pin(fin));

    // Red module 11 sits after the blue run
    function automatic logic [7:0] caddr(input int c, input int m);
        if (c == 0) return (m == 11) ? 8'h37 : 8'(8'h14 + m);
        return (c == 1) ? 8'(8'h1F + m) : 8'(8'h2B + m);
    endfunction

    function automatic logic [7:0] pat(input int c, input int m);
        return 8'(8'h11 * m + c + 1);
    endfunction

    function automatic logic [7:0] mix_out(input int c, input int m);
        return (c == 0) ? red[8*m +: 8] : (c == 1) ? green[8*m +: 8] : blue[8*m +: 8];
    endfunction

    // Expected gain: FFh counts as unity, otherwise value over 256
    function automatic logic [11:0] exp_mix(input logic [11:0] l, input logic [7:0] s);
        int g;
        g = (s == 8'hFF) ? 256 : int'(s);
        return 12'((int'(l) * g) >> 8);
    endfunction

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] got;
        logic val;
        host.read(a, got, val);
        `CHK("read valid", 1'b1, val)
        `CHK("register read", e, got)
    endtask

    // Event sources held for one cycle, g = {por, uv, ot}
    task automatic ev(input logic [2:0] g, input logic [15:0] o, input logic [15:0] s);
        @(negedge clk);
        por = g[2];
        uv = g[1];
        ot = g[0];
        open_det = o;
        short_det = s;
        @(negedge clk);
        por = 1'b0;
        uv = 1'b0;
        ot = 1'b0;
        open_det = 16'h0000;
        short_det = 16'h0000;
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        $display("Error watchdog expected done seen hang");
        stop_test();
    end

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        for (int c = 0; c < 3; c++) begin
            for (int m = 0; m < 12; m++) rchk(caddr(c, m), 8'h00);
        end
        foreach (regs[i]) rchk(regs[i], 8'h00);
        $display("test defaults done");
        for (int c = 0; c < 3; c++) begin
            for (int m = 0; m < 12; m++) host.write(caddr(c, m), pat(c, m));
        end
        for (int c = 0; c < 3; c++) begin
            for (int m = 0; m < 12; m++) begin
                rchk(caddr(c, m), pat(c, m));
                `CHK("mix port", pat(c, m), mix_out(c, m))
            end
        end
        $display("test color map done");
        level = 12'hABC;
        foreach (scale[i]) begin
            host.write(8'h14, scale[i]);
            @(negedge clk);
            `CHK("mixed level", exp_mix(12'hABC, scale[i]), mixl[11:0])
        end
        $display("test scaling done");
        // A non-key value at 38h must leave the bank alone
        foreach (regs[i]) host.write(regs[i], (regs[i] == 8'h38) ? 8'hFE : 8'hFF);
        rchk(8'h66, 8'h3F);
        `CHK("global dim", 6'h3F, gdim)
        rchk(8'h67, 8'h03);
        `CHK("fault delay", 2'h3, fdel)
        rchk(8'h68, 8'h7C);
        rchk(8'h69, 8'h00);
        rchk(8'h38, 8'h00);
        host.write(8'h6A, 8'h00);
        host.write(8'h6B, 8'h00);
        ev(3'b111, 16'hFFFF, 16'hFFFF);
        rchk(8'h65, 8'h00);
        `CHK("fault enable", 1'b1, foe_n)
        $display("test reserved and masks done");
        host.write(8'h68, 8'h00);
        ev(3'b001, 16'h0000, 16'h0000);
        rchk(8'h65, 8'h04);
        `CHK("fault pin", 1'b0, fin)
        ev(3'b110, 16'h0008, 16'h0200);
        repeat (5) @(negedge clk);
        rchk(8'h65, 8'h1F);
        host.write(8'h68, 8'h02);
        rchk(8'h65, 8'h10);
        rchk(8'h68, 8'h00);
        host.write(8'h68, 8'h01);
        rchk(8'h65, 8'h00);
        `CHK("fault enable", 1'b1, foe_n)
        host.write(8'h6A, 8'h08);
        host.write(8'h6B, 8'h08);
        rchk(8'h6B, 8'h08);
        ev(3'b000, 16'h0808, 16'h0000);
        rchk(8'h65, 8'h00);
        ev(3'b000, 16'h0010, 16'h0000);
        rchk(8'h65, 8'h01);
        host.write(8'h68, 8'h60);
        ev(3'b110, 16'h0000, 16'h0000);
        rchk(8'h65, 8'h01);
        $display("test fault flags done");
        host.write(8'h38, 8'h01);
        rchk(8'h66, 8'h3F);
        host.write(8'h38, 8'hFF);
        `CHK("reset pulse", 1'b1, srst)
        @(negedge clk);
        `CHK("reset pulse", 1'b0, srst)
        @(negedge clk);
        `CHK("reset pulse", 1'b0, srst)
        foreach (regs[i]) rchk(regs[i], 8'h00);
        rchk(caddr(0, 11), 8'h00);
        `CHK("global dim", 6'h00, gdim)
        $display("test soft reset done");
        stop_test();
    end
endmodule
